// [verilog/dsdos_converter.sv]
// Converter end: phase sequencer, zero-crossing sampler, result counter, digit strobes
`timescale 1ns/1ps
`default_nettype none
module dsdos_converter
(
  input  wire logic sys_clk_i,
  input  wire logic reset_i,
  input  wire logic comparator_i,
  output logic      overrange_blink_o,
  dsdos_if.converter link
);
  import dsdos_pkg::*;

  typedef struct packed {
    dsdos_phase_t phase;
    logic [14:0]  cnt;
    logic [14:0]  result;
    logic         first_ref;
    logic         cmp_s1;
    logic         cmp_s2;
    logic         pol;
    logic         ovr;
    logic         und;
    logic         blink;
    logic [2:0]   dig;
    logic [2:0]   idx;
    logic [7:0]   gap;
    logic         strobe;
    logic [3:0]   value;
    logic         busy;
  } dsdos_conv_t;

  dsdos_conv_t s;
  dsdos_conv_t next_s;

  // Decimal digit of a count, index 4 is the top (half) digit
  function automatic logic [3:0] digit_of(input logic [14:0] v, input logic [2:0] i);
    logic [14:0] q;
    q = v;
    for (int k = 0; k < 4; k++)
    begin
      if (k < int'(i))
      begin
        q = 15'(q / 15'd10);
      end
    end
    digit_of = 4'(q % 15'd10);
  endfunction

  // Sequencer: auto-zero, signal integrate, reference integrate, output burst
  always_comb
  begin
    next_s        = s;
    next_s.cmp_s1 = comparator_i;
    next_s.cmp_s2 = s.cmp_s1;
    next_s.strobe = 1'b0;
    case (s.phase)
      DSDOS_AUTO_ZERO:
      begin
        next_s.busy = 1'b0;
        if (s.cnt < 15'(AZ_COUNTS - 1))
        begin
          next_s.cnt = 15'(s.cnt + 15'd1);
        end
        else if (link.run_cmd && !link.hold_cmd)
        begin
          next_s.cnt   = CNT_RESET;
          next_s.phase = DSDOS_SIG_INT;
          next_s.busy  = 1'b1;
        end
      end
      DSDOS_SIG_INT:
      begin
        next_s.cnt = 15'(s.cnt + 15'd1);
        if (s.cnt == 15'(SIG_INT_COUNTS - 1))
        begin
          next_s.cnt       = CNT_RESET;
          next_s.pol       = s.cmp_s2;
          next_s.first_ref = 1'b1;
          next_s.phase     = DSDOS_REF_INT;
        end
      end
      DSDOS_REF_INT:
      begin
        next_s.first_ref = 1'b0;
        if (!s.first_ref)
        begin
          next_s.cnt = 15'(s.cnt + 15'd1);
        end
        if ((s.cmp_s2 != s.pol && !s.first_ref) ||
            s.cnt == 15'(REF_MAX_COUNTS - 1))
        begin
          next_s.result = (s.cnt >= 15'(OVERRANGE_COUNT)) ? CNT_RESET : s.cnt;
          next_s.ovr    = s.cnt >= 15'(OVERRANGE_COUNT);
          next_s.und    = s.cnt < 15'(UNDERRANGE_COUNT);
          next_s.blink  = (s.cnt >= 15'(OVERRANGE_COUNT)) ? !s.blink : 1'b0;
          next_s.dig    = 3'd4;
          next_s.gap    = 8'h00;
          next_s.busy   = 1'b0;
          next_s.phase  = DSDOS_OUTPUT;
        end
      end
      DSDOS_OUTPUT:
      begin
        next_s.gap = 8'(s.gap + 8'd1);
        if (s.gap == 8'h00)
        begin
          next_s.strobe = 1'b1;
          next_s.idx    = s.dig;               // Index moves only with its strobe
          next_s.value  = digit_of(s.result, s.dig);
        end
        if (s.gap == 8'(STROBE_GAP - 1))
        begin
          next_s.gap = 8'h00;
          next_s.dig = 3'(s.dig - 3'd1);
          if (s.dig == 3'd0)
          begin
            next_s.cnt   = CNT_RESET;
            next_s.phase = link.hold_cmd ? DSDOS_HOLD : DSDOS_AUTO_ZERO;
          end
        end
      end
      DSDOS_HOLD:
      begin
        if (!link.hold_cmd)
        begin
          next_s.phase = DSDOS_AUTO_ZERO;
        end
      end
      default:
      begin
        next_s.phase = DSDOS_AUTO_ZERO;
      end
    endcase
  end

  // One register for all state; reset restarts at auto-zero
  always_ff @(posedge sys_clk_i)
  begin
    if (reset_i)
    begin
      s <= '0;
      s.phase <= DSDOS_AUTO_ZERO;
    end
    else
    begin
      s <= next_s;
    end
  end

  assign link.digit_strobe = s.strobe;
  assign link.digit_index  = s.idx;
  assign link.digit_value  = s.value;
  assign link.polarity     = s.pol;
  assign link.overrange    = s.ovr;
  assign link.underrange   = s.und;
  assign link.busy         = s.busy;
  assign overrange_blink_o = s.blink;
endmodule : dsdos_converter
`default_nettype wire

// [verilog/dsdos_pkg.sv]
// Shared constants and types for the dual-slope digit output sequencer
package dsdos_pkg;
  localparam int unsigned SIG_INT_COUNTS   = 10000;
  localparam int unsigned REF_MAX_COUNTS   = 20001;
  localparam int unsigned AZ_COUNTS        = 10001;
  localparam int unsigned NUM_DIGITS       = 5;
  localparam int unsigned STROBE_GAP       = 200;
  localparam int unsigned OVERRANGE_COUNT  = 20000;
  localparam int unsigned UNDERRANGE_COUNT = 900;
  localparam logic [3:0]  SEL_TOP          = 4'h0;
  localparam int unsigned TOP_POL_BIT      = 1;
  localparam int unsigned TOP_OVR_BIT      = 2;
  localparam int unsigned TOP_UND_BIT      = 3;
  localparam logic [3:0]  BLANK_NIBBLE     = 4'hf;
  localparam logic [14:0] CNT_RESET        = 15'h0000;

  typedef enum logic [2:0] {DSDOS_AUTO_ZERO, DSDOS_SIG_INT, DSDOS_REF_INT,
                            DSDOS_OUTPUT, DSDOS_HOLD} dsdos_phase_t;
endpackage : dsdos_pkg

// [verilog/dsdos_if.sv]
// Interface joining converter sequencer and framing logic
`timescale 1ns/1ps
`default_nettype none
interface dsdos_if;
  logic       digit_strobe;
  logic [2:0] digit_index;
  logic [3:0] digit_value;
  logic       polarity;
  logic       overrange;
  logic       underrange;
  logic       busy;
  logic       run_cmd;
  logic       hold_cmd;
  modport converter (output digit_strobe, digit_index, digit_value, polarity,
                     overrange, underrange, busy, input run_cmd, hold_cmd);
  modport framer (input digit_strobe, digit_index, digit_value, polarity,
                  overrange, underrange, busy, output run_cmd, hold_cmd);
endinterface : dsdos_if
`default_nettype wire

// [verilog/dsdos_framer.sv]
// Framing end: builds serial words and display data from the digit strobes
`timescale 1ns/1ps
`default_nettype none
module dsdos_framer
(
  input  wire logic        sys_clk_i,
  input  wire logic        reset_i,
  input  wire logic        received_word_i,
  input  wire logic        hold_request_i,
  output logic             tx_load_o,
  output logic [7:0]       tx_word_o,
  output logic             even_parity_select_o,
  output logic             received_word_flag_clear_o,
  output logic [15:0]      display_digits_o,
  dsdos_if.framer          link
);
  import dsdos_pkg::*;

  typedef struct packed {
    logic        load;
    logic [7:0]  word;
    logic        eps;
    logic        flag_clr;
    logic        run;
    logic        hold;
    logic [15:0] disp;
    logic        rw_s1;
    logic        rw_s2;
    logic        hr_s1;
    logic        hr_s2;
  } dsdos_frm_t;

  dsdos_frm_t s;
  dsdos_frm_t next_s;
  logic [3:0] sel;
  logic [3:0] low;

  // Digit code: one-hot by position, top digit code all zero
  always_comb
  begin
    sel = (link.digit_index == 3'd4) ? SEL_TOP : 4'(4'h8 >> (3'd3 - link.digit_index));
    low = link.digit_value;
    if (link.digit_index == 3'd4)
    begin
      low[TOP_POL_BIT] = link.polarity;
      low[TOP_OVR_BIT] = link.overrange;
      low[TOP_UND_BIT] = link.underrange;
    end
  end

  // Word load on each strobe, parity from sign, command handling
  always_comb
  begin
    next_s          = s;
    next_s.load     = link.digit_strobe;
    next_s.flag_clr = link.busy;
    // Pin inputs pass two flops before any logic reads them
    next_s.rw_s1    = received_word_i;
    next_s.rw_s2    = s.rw_s1;
    next_s.hr_s1    = hold_request_i;
    next_s.hr_s2    = s.hr_s1;
    next_s.hold     = s.hr_s2;
    if (s.rw_s2)
    begin
      next_s.run = 1'b1;
    end
    else if (link.busy)
    begin
      next_s.run = 1'b0;
    end
    if (link.digit_strobe)
    begin
      next_s.word = {sel, low};
      if (link.digit_index == 3'd4)
      begin
        next_s.eps = link.polarity;
      end
      if (link.digit_index != 3'd4)
      begin
        next_s.disp[4 * link.digit_index +: 4] =
          link.overrange ? BLANK_NIBBLE : link.digit_value;
      end
    end
  end

  // One register for all framing state
  always_ff @(posedge sys_clk_i)
  begin
    if (reset_i)
    begin
      s <= '0;
    end
    else
    begin
      s <= next_s;
    end
  end

  assign tx_load_o                  = s.load;
  assign tx_word_o                  = s.word;
  assign even_parity_select_o       = s.eps;
  assign received_word_flag_clear_o = s.flag_clr;
  assign display_digits_o           = s.disp;
  assign link.run_cmd               = s.run;
  assign link.hold_cmd              = s.hold;
endmodule : dsdos_framer
`default_nettype wire

// [dv/dsdos_sva.sv]
// Checker for the link between converter and framing ends
`timescale 1ns/1ps
`default_nettype none
module dsdos_sva (
  input wire logic       sys_clk_i,
  input wire logic       reset_i,
  input wire logic       digit_strobe,
  input wire logic [2:0] digit_index,
  input wire logic [3:0] digit_value,
  input wire logic       polarity,
  input wire logic       overrange,
  input wire logic       busy,
  input wire logic       run_cmd,
  input wire logic       hold_cmd
);
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (reset_i);
  int unsigned busy_cnt;
  // Busy stretch length, far too long for a repetition
  always_ff @(posedge sys_clk_i)
    busy_cnt <= (reset_i || !busy) ? 0 : busy_cnt + 1;
  sequence s_step; digit_strobe && digit_index != 3'h0; endsequence
  property p_len; $fell(busy) |-> busy_cnt >= 10000 && busy_cnt <= 30010; endproperty
  a_len: assert property (p_len) else $error("busy length");
  property p_pulse; digit_strobe |=> !digit_strobe; endproperty
  a_pulse: assert property (p_pulse) else $error("strobe width");
  property p_step; s_step |-> ##200 digit_strobe && digit_index == $past(digit_index, 200) - 3'h1;
  endproperty
  a_step: assert property (p_step) else $error("strobe order");
  property p_quiet; busy |-> !digit_strobe; endproperty
  a_quiet: assert property (p_quiet) else $error("strobe while busy");
  property p_stand; !digit_strobe |-> $stable(digit_index); endproperty
  a_stand: assert property (p_stand) else $error("index moved");
  property p_pol; s_step |-> ##200 polarity == $past(polarity, 200); endproperty
  a_pol: assert property (p_pol) else $error("polarity moved");
  property p_zero; digit_strobe && overrange |-> digit_value == 4'h0; endproperty
  a_zero: assert property (p_zero) else $error("overload not zero");
  property p_run; $rose(busy) |-> $past(run_cmd) && !$past(hold_cmd); endproperty
  a_run: assert property (p_run) else $error("start not commanded");
  property p_rst; disable iff (1'b0) reset_i |=> !digit_strobe && !busy; endproperty
  a_rst: assert property (p_rst) else $error("reset not idle");
endmodule // dsdos_sva
`default_nettype wire

// [dv/tb_dual_slope_digit_output_sequencer.sv]
// Bench for the converter and framing ends joined back to back
`timescale 1ns/1ps
`default_nettype none
module tb_dual_slope_digit_output_sequencer;
  import dsdos_pkg::*;
  logic        sys_clk_i = 1'b0;
  logic        reset_i = 1'b1;
  logic        comparator_i = 1'b0;
  logic        received_word_i = 1'b0;
  logic        hold_request_i = 1'b0;
  logic        tx_load_o, parity_o, flag_clear_o, blink_o;
  logic [7:0]  tx_word_o;
  logic [15:0] display_o;
  logic [7:0]  lfsr = 8'h22;
  int          n_errors = 0;
  int          checks_done = 0;
  dsdos_if link ();
  dsdos_converter u_dsdos_converter (.sys_clk_i(sys_clk_i), .reset_i(reset_i),
    .comparator_i(comparator_i), .overrange_blink_o(blink_o), .link(link));
  dsdos_framer u_dsdos_framer (.sys_clk_i(sys_clk_i), .reset_i(reset_i),
    .received_word_i(received_word_i), .hold_request_i(hold_request_i),
    .tx_load_o(tx_load_o), .tx_word_o(tx_word_o), .even_parity_select_o(parity_o),
    .received_word_flag_clear_o(flag_clear_o), .display_digits_o(display_o), .link(link));
  dsdos_sva u_dsdos_sva (.sys_clk_i(sys_clk_i), .reset_i(reset_i),
    .digit_strobe(link.digit_strobe), .digit_index(link.digit_index),
    .digit_value(link.digit_value), .polarity(link.polarity), .overrange(link.overrange),
    .busy(link.busy), .run_cmd(link.run_cmd), .hold_cmd(link.hold_cmd));
  // Free-running 100 MHz clock
  initial
  begin
    forever #5 sys_clk_i = ~sys_clk_i;
  end
  function automatic logic [7:0] lfsr_next(input logic [7:0] v);
    return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
  endfunction
  function automatic logic [3:0] sel_code(input int k);
    return (k == 0) ? 4'h0 : 4'h8 >> (k - 1);
  endfunction
  // Inputs move 1 ns after the edge, never racing it
  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk_i);
    #1;
  endtask
  task automatic stop_test();
    $display("checks %0d errors %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // A wait that runs out ends the run as a failure
  task automatic timeout(input int i, input int bound);
    if (i >= bound)
    begin
      n_errors++;
      stop_test();
    end
  endtask
  task automatic wait_busy(input logic lvl, input int bound);
    int i;
    for (i = 0; i < bound && link.busy !== lvl; i++)
      tick(1);
    timeout(i, bound);
  endtask
  // One measurement; comparator flips n clocks into the reference phase, and never flips when n is 20000 or more
  task automatic conv(input int n, input logic pol, input logic hold);
    logic [7:0] w [5];
    int i;
    int cnt;
    logic ovr;
    ovr = (n >= 20000);
    comparator_i = pol;
    received_word_i = 1'b1;
    wait_busy(1'b1, 10500);
    received_word_i = 1'b0;
    hold_request_i = hold;
    tick(1);
    check("flag_clear", flag_clear_o, 1'b1);
    if (!ovr)
    begin
      tick(9999 + n);
      comparator_i = ~pol;
    end
    wait_busy(1'b0, ovr ? 31000 : 21000);
    for (int k = 0; k < 5; k++)
    begin
      for (i = 0; i < 300 && tx_load_o !== 1'b1; i++)
        tick(1);
      timeout(i, 300);
      w[k] = tx_word_o;
      check("parity", parity_o, pol);
      check("select", w[k][7:4], sel_code(k));
      tick(1);
    end
    cnt = w[0][0] * 10000 + w[1][3:0] * 1000 + w[2][3:0] * 100 + w[3][3:0] * 10 + w[4][3:0];
    check("top_flags", w[0][3:1], {n < 900 && !ovr, ovr, pol});
    check("count", ovr ? cnt == 0 : cnt >= n - 3 && cnt <= n + 3, 1'b1);
    tick(2);
    check("display", display_o, ovr ? 16'hffff : {w[1][3:0], w[2][3:0], w[3][3:0], w[4][3:0]});
    check("blink", blink_o, ovr);
  endtask
  // Underrange reading with hold, then an overload
  initial
  begin
    tick(2);
    reset_i = 1'b0;
    lfsr = lfsr_next(lfsr);
    conv(500 + lfsr, lfsr[0], 1'b1);
    received_word_i = 1'b1;
    tick(10500);
    check("held", link.busy, 1'b0);
    hold_request_i = 1'b0;
    lfsr = lfsr_next(lfsr);
    conv(25000, lfsr[0], 1'b0);
    stop_test();
  end
endmodule // tb_dual_slope_digit_output_sequencer
`default_nettype wire
